// ---- include/cic_pkg.sv ----
// Shared constants and types of the conflict instruction cache.
// Assumes a 24-bit instruction address and a 24-bit instruction word.
package cic_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 24; // Instruction address width.
    localparam int INSTR_W = 24; // Instruction word width.
    localparam int SET_W = 5; // Set index is address bits 4..0.
    localparam int SETS = 32; // Number of two-entry sets.
    localparam int TAG_W = ADDR_W - SET_W; // Stored upper address bits.
    // ------------------------------------------------------------
    // Cache mode control register
    // ------------------------------------------------------------
    localparam int CTL_W = 8; // Register width.
    localparam int CTL_DM_EN_BIT = 5; // Data-memory bus caching enable.
    localparam int CTL_FRZ_BIT = 6; // Freeze bit.
    localparam int CTL_PM_EN_BIT = 7; // Program-memory bus caching enable.
    localparam logic [7:0] CTL_RESET = 8'ha0; // Both enables on, freeze off.
    localparam logic [7:0] CTL_MASK = 8'he0; // Implemented bits.
    // ------------------------------------------------------------
    // Effect latencies of a control write, in cycles
    // ------------------------------------------------------------
    localparam int EN_EFFECT_LAT = 5; // Enable bits.
    localparam int FRZ_EFFECT_LAT = 4; // Freeze bit.
    // ------------------------------------------------------------
    // Conflict lookup request from the sequencer.
    // ------------------------------------------------------------
    typedef struct packed {
        logic pm_data; // Executing instruction uses the program-memory bus.
        logic dm_data; // Data-memory bus transfer this cycle.
        logic [ADDR_W-1:0] dm_block; // Block targeted by that transfer.
        logic [ADDR_W-1:0] fetch_block; // Block of the current fetch.
        logic [ADDR_W-1:0] fetch_addr; // Fetch address, three ahead of execute.
    } cic_req_t;
endpackage : cic_pkg

// ---- verilog/cic_cache.sv ----
// Conflict instruction cache: 64 entries in 32 two-way sets, filled on
// fetch conflicts, controlled by the cache mode control register.
// Assumes the sequencer stops issuing lookups while a miss is stalled and
// presents the memory instruction during the stall cycle.
//
// Function
// - Program-bus data access is a bus conflict.
// - Data-bus access to fetch block: block conflict.
// - Look up conflicts; hit delivers without stall.
// - Miss fetches next cycle, one stall.
// - Cache the n+3 fetch, not executing one.
// - Fill only when enabled and not frozen.
// - 64 entries, 32 sets, index bits 4..0.
// - Hit needs valid entry with matching address.
// - Recency bit points at entry not used.
// - Fill into recency entry, then invert bit.
// - Reset: all invalid, enabled, unfrozen.
// - Bit 5 enables data-bus conflict caching.
// - Bit 6 freezes cache contents.
// - Bit 7 enables program-bus conflict caching.
// - Reset sets enables, clears freeze.
// - Flush clears every valid bit.
// - Register reached only by register moves.
// - Writes act after five cycles, freeze four.
`timescale 1ns/1ps
module cic_cache (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_req_valid,
    input wire cic_pkg::cic_req_t i_req,
    input wire logic [cic_pkg::INSTR_W-1:0] i_mem_instr,
    input wire logic i_flush,
    input wire logic i_reg_wr,
    input wire logic [cic_pkg::CTL_W-1:0] i_reg_wdata,
    output logic [cic_pkg::CTL_W-1:0] o_reg_rdata,
    output logic o_hit,
    output logic [cic_pkg::INSTR_W-1:0] o_instr,
    output logic o_stall
);
    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Set index of an address.
    function automatic logic [cic_pkg::SET_W-1:0] set_of(
        input logic [cic_pkg::ADDR_W-1:0] a);
        set_of = a[cic_pkg::SET_W-1:0];
    endfunction : set_of

    // Stored upper part of an address.
    function automatic logic [cic_pkg::TAG_W-1:0] tag_of(
        input logic [cic_pkg::ADDR_W-1:0] a);
        tag_of = a[cic_pkg::ADDR_W-1:cic_pkg::SET_W];
    endfunction : tag_of

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [1:0][cic_pkg::SETS-1:0] vld_q; // Valid bit per way and set.
    logic [cic_pkg::SETS-1:0] lru_q; // Entry not used last per set.
    logic [cic_pkg::TAG_W-1:0] tag0_q [cic_pkg::SETS]; // Way 0 addresses.
    logic [cic_pkg::TAG_W-1:0] tag1_q [cic_pkg::SETS]; // Way 1 addresses.
    logic [cic_pkg::INSTR_W-1:0] dat0_q [cic_pkg::SETS]; // Way 0 words.
    logic [cic_pkg::INSTR_W-1:0] dat1_q [cic_pkg::SETS]; // Way 1 words.
    logic [cic_pkg::CTL_W-1:0] ctl_q; // Architectural control value.
    logic [cic_pkg::EN_EFFECT_LAT-1:0] pm_pipe_q; // Delay of bit 7.
    logic [cic_pkg::EN_EFFECT_LAT-1:0] dm_pipe_q; // Delay of bit 5.
    logic [cic_pkg::FRZ_EFFECT_LAT-1:0] frz_pipe_q; // Delay of bit 6.
    logic pend_q; // A miss is waiting for its memory fetch.
    logic pend_fill_q; // That miss may be written into the cache.
    logic [cic_pkg::ADDR_W-1:0] pend_addr_q; // Address of the missed fetch.

    // ------------------------------------------------------------
    // Conflict detection and lookup
    // ------------------------------------------------------------
    logic bus_conf; // Bus conflict.
    logic blk_conf; // Block conflict.
    logic req; // Lookup taken this cycle.
    logic [cic_pkg::SET_W-1:0] idx; // Indexed set.
    logic hit0; // Way 0 matches.
    logic hit1; // Way 1 matches.
    logic hit_c; // Lookup hits.
    logic pm_en; // Effective program-bus enable.
    logic dm_en; // Effective data-bus enable.
    logic frz; // Effective freeze.
    logic fill_ok; // A miss now may later be cached.
    logic fill_c; // Fill happens this cycle.
    logic [cic_pkg::INSTR_W-1:0] hit_data; // Word of the matching way.

    // A lookup is taken only for a real conflict. While a miss waits for
    // memory the sequencer is stalled, so a request in that cycle is ignored.
    assign bus_conf = i_req.pm_data;
    assign blk_conf = i_req.dm_data && (i_req.dm_block == i_req.fetch_block);
    assign req = i_req_valid && !pend_q && (bus_conf || blk_conf);
    assign idx = set_of(i_req.fetch_addr);
    assign hit0 = vld_q[0][idx] && (tag0_q[idx] == tag_of(i_req.fetch_addr));
    assign hit1 = vld_q[1][idx] && (tag1_q[idx] == tag_of(i_req.fetch_addr));
    assign hit_c = hit0 || hit1;
    assign hit_data = hit1 ? dat1_q[idx] : dat0_q[idx];
    assign pm_en = pm_pipe_q[cic_pkg::EN_EFFECT_LAT-1];
    assign dm_en = dm_pipe_q[cic_pkg::EN_EFFECT_LAT-1];
    assign frz = frz_pipe_q[cic_pkg::FRZ_EFFECT_LAT-1];
    // Either conflict kind counts under its own enable, and freeze blocks both.
    assign fill_ok = ((bus_conf && pm_en) || (blk_conf && dm_en)) && !frz;
    assign fill_c = pend_q && pend_fill_q && !i_flush;

    // ------------------------------------------------------------
    // Control register, written by a register move only
    // ------------------------------------------------------------
    // Reserved bits are dropped so they read as zero.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl_q <= cic_pkg::CTL_RESET;
        end else if (i_reg_wr) begin
            ctl_q <= i_reg_wdata & cic_pkg::CTL_MASK;
        end
    end

    // Read value of the register move; it shows the written value at once.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= cic_pkg::CTL_RESET;
        end else if (i_reg_wr) begin
            o_reg_rdata <= i_reg_wdata & cic_pkg::CTL_MASK;
        end else begin
            o_reg_rdata <= ctl_q;
        end
    end

    // Delay lines that give each mode bit its effect latency.
    // The pipes reset to the reset mode, so a write made right after reset
    // is the first change that reaches the lookup logic.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pm_pipe_q <= '1;
            dm_pipe_q <= '1;
            frz_pipe_q <= '0;
        end else begin
            pm_pipe_q <= {pm_pipe_q[cic_pkg::EN_EFFECT_LAT-2:0], ctl_q[cic_pkg::CTL_PM_EN_BIT]};
            dm_pipe_q <= {dm_pipe_q[cic_pkg::EN_EFFECT_LAT-2:0], ctl_q[cic_pkg::CTL_DM_EN_BIT]};
            frz_pipe_q <= {frz_pipe_q[cic_pkg::FRZ_EFFECT_LAT-2:0], ctl_q[cic_pkg::CTL_FRZ_BIT]};
        end
    end

    // ------------------------------------------------------------
    // Answer to the sequencer
    // ------------------------------------------------------------
    // A hit answers with the word and no stall; a miss raises one stall.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hit <= 1'b0;
            o_stall <= 1'b0;
            o_instr <= '0;
        end else begin
            o_hit <= req && hit_c;
            o_stall <= req && !hit_c;
            if (req && hit_c) begin
                o_instr <= hit_data;
            end
        end
    end

    // Miss bookkeeping for the stall cycle.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_q <= 1'b0;
            pend_fill_q <= 1'b0;
            pend_addr_q <= '0;
        end else begin
            pend_q <= req && !hit_c;
            pend_fill_q <= req && !hit_c && fill_ok;
            if (req && !hit_c) begin
                pend_addr_q <= i_req.fetch_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // Valid bits and recency
    // ------------------------------------------------------------
    // Flush clears all entries and overrides a fill in the same cycle.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vld_q <= '0;
        end else if (i_flush) begin
            vld_q <= '0;
        end else if (fill_c) begin
            vld_q[lru_q[set_of(pend_addr_q)]][set_of(pend_addr_q)] <= 1'b1;
        end
    end

    // Recency points at the unused way after a hit, flips after a fill.
    // A hit and a fill never share a cycle, because a pending miss blocks lookups.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lru_q <= '0;
        end else if (fill_c) begin
            lru_q[set_of(pend_addr_q)] <= !lru_q[set_of(pend_addr_q)];
        end else if (req && hit_c) begin
            lru_q[idx] <= !hit1;
        end
    end

    // Entry contents need no reset; valid bits guard them.
    always_ff @(posedge i_sys_clk) begin
        if (fill_c && !lru_q[set_of(pend_addr_q)]) begin
            tag0_q[set_of(pend_addr_q)] <= tag_of(pend_addr_q);
            dat0_q[set_of(pend_addr_q)] <= i_mem_instr;
        end
        if (fill_c && lru_q[set_of(pend_addr_q)]) begin
            tag1_q[set_of(pend_addr_q)] <= tag_of(pend_addr_q);
            dat1_q[set_of(pend_addr_q)] <= i_mem_instr;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Set and way that the pending fill writes, used by the checks below.
    logic [cic_pkg::SET_W-1:0] fill_set; // Set of the missed fetch.
    logic fill_way; // Way named by the recency bit of that set.
    assign fill_set = set_of(pend_addr_q);
    assign fill_way = lru_q[fill_set];

    // A control write followed by quiet cycles.
    sequence s_wr_quiet5;
        i_reg_wr ##1 (!i_reg_wr)[*5];
    endsequence
    sequence s_wr_quiet4;
        i_reg_wr ##1 (!i_reg_wr)[*4];
    endsequence

    // Both enables follow the written bits six edges after the write edge.
    a_enable_latency: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_wr_quiet5 |=> ((pm_en == $past(i_reg_wdata[cic_pkg::CTL_PM_EN_BIT], 6))
        && (dm_en == $past(i_reg_wdata[cic_pkg::CTL_DM_EN_BIT], 6))))
        else $error("Enable latency wrong.");
    // Freeze follows the written bit one edge sooner than the enables.
    a_freeze_latency: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_wr_quiet4 |=> (frz == $past(i_reg_wdata[cic_pkg::CTL_FRZ_BIT], 5)))
        else $error("Freeze latency wrong.");
    // A hit answers with the cached word and no stall.
    a_hit_word: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (req && hit_c) |=> (o_hit && !o_stall && o_instr == $past(hit_data)))
        else $error("Hit did not deliver the cached word.");
    // A miss stalls for exactly one cycle.
    a_miss_stall: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (req && !hit_c) |=> (o_stall && !o_hit) ##1 !o_stall)
        else $error("Miss did not stall exactly one cycle.");
    // A flush leaves no entry valid.
    a_flush_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_flush |=> (vld_q == '0))
        else $error("Flush left a valid entry.");
    // A hit moves the recency bit to the other way.
    a_hit_recency: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (req && hit_c && !fill_c) |=> (lru_q[$past(idx)] == !$past(hit1)))
        else $error("Recency not moved to the unused way.");
    // A miss taken while frozen changes no valid bit.
    a_frozen_nofill: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (req && !hit_c && frz) |=> ##1 $stable(vld_q) || $past(i_flush))
        else $error("Fill while frozen.");
    // Every fill inverts the recency bit of its set.
    a_fill_flip: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        fill_c |=> (lru_q[set_of(pend_addr_q)] != $past(lru_q[set_of(pend_addr_q)])))
        else $error("Fill did not invert recency.");
    // Reserved control bits always read as zero.
    a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ((o_reg_rdata & ~cic_pkg::CTL_MASK) == 8'h00))
        else $error("Reserved control bits read nonzero.");
    // A program-bus data access made while no miss is pending gets an answer one edge later.
    a_bus_conflict: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_req_valid && !pend_q && i_req.pm_data) |=> (o_hit || o_stall))
        else $error("Bus conflict was not looked up.");
    // A data-bus transfer into the fetch block is a conflict as well.
    a_block_conflict: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_req_valid && !pend_q && i_req.dm_data && (i_req.dm_block == i_req.fetch_block))
        |=> (o_hit || o_stall))
        else $error("Block conflict was not looked up.");
    // Without any conflict the cache stays silent.
    a_no_conflict: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (!i_req.pm_data && !(i_req.dm_data && (i_req.dm_block == i_req.fetch_block)))
        |=> (!o_hit && !o_stall))
        else $error("Answer without a conflict.");
    // A granted fill leaves the entry named by recency valid.
    a_fill_valid: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        fill_c |=> vld_q[$past(fill_way)][$past(fill_set)])
        else $error("Fill did not validate its entry.");
    // A fill into way 0 stores the memory word and its address.
    a_fill_way0: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (fill_c && !fill_way) |=> ((dat0_q[$past(fill_set)] == $past(i_mem_instr))
        && (tag0_q[$past(fill_set)] == $past(tag_of(pend_addr_q)))))
        else $error("Way 0 fill stored the wrong entry.");
    // A fill into way 1 stores the memory word and its address.
    a_fill_way1: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (fill_c && fill_way) |=> ((dat1_q[$past(fill_set)] == $past(i_mem_instr))
        && (tag1_q[$past(fill_set)] == $past(tag_of(pend_addr_q)))))
        else $error("Way 1 fill stored the wrong entry.");
    // A register move reads back the written value with reserved bits cleared.
    a_ctl_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_reg_wr |=> (o_reg_rdata == ($past(i_reg_wdata) & cic_pkg::CTL_MASK)))
        else $error("Control readback wrong.");
    // With the program-bus enable off, a miss that is only a bus conflict is not cached.
    a_pm_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (req && !hit_c && bus_conf && !blk_conf && !pm_en) |=> !pend_fill_q)
        else $error("Program-bus miss cached while disabled.");
    // With the data-bus enable off, a miss that is only a block conflict is not cached.
    a_dm_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (req && !hit_c && blk_conf && !bus_conf && !dm_en) |=> !pend_fill_q)
        else $error("Data-bus miss cached while disabled.");
endmodule : cic_cache

// ---- dv/cic_seq_model.sv ----
// Behavioural model of the sequencer fetch side that feeds the cache its memory word.
// Assumes the bench drives the lookup request and this model only supplies memory data.
`timescale 1ns/1ps
module cic_seq_model (
    input wire logic i_sys_clk,
    input wire logic i_req_valid,
    input wire logic [23:0] i_fetch_addr,
    input wire logic i_stall,
    output logic [23:0] o_mem_instr
);
    logic [23:0] addr_q; // Address of the last fetch request.
    logic [23:0] word; // Program memory content at that address.
    // The last fetch address is kept so the stall cycle can serve it.
    always_ff @(posedge i_sys_clk) begin
        if (i_req_valid) begin
            addr_q <= i_fetch_addr;
        end
    end
    // Memory word is served only in the stall cycle, else the inverse.
    always_comb begin
        word = {~addr_q[11:0], addr_q[11:0]};
        o_mem_instr = i_stall ? word : ~word;
    end
endmodule : cic_seq_model

// ---- dv/cic_cache_bench.sv ----
// Self-checking bench for the conflict instruction cache.
// Assumes the cache and the fetch-side model are compiled first.
`timescale 1ns/1ps
module cic_cache_bench;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_req_valid = 1'b0;
    cic_pkg::cic_req_t i_req = '0;
    logic [23:0] i_mem_instr;
    logic i_flush = 1'b0;
    logic i_reg_wr = 1'b0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic [7:0] o_reg_rdata;
    logic o_hit;
    logic [23:0] o_instr;
    logic o_stall;
    int miscompares = 0;
    int checked = 0;
    always #12.5 i_sys_clk = ~i_sys_clk;
    cic_cache u_cic_cache (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_req_valid(i_req_valid), .i_req(i_req), .i_mem_instr(i_mem_instr),
        .i_flush(i_flush), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_hit(o_hit), .o_instr(o_instr), .o_stall(o_stall));
    cic_seq_model u_cic_seq_model (.i_sys_clk(i_sys_clk), .i_req_valid(i_req_valid),
        .i_fetch_addr(i_req.fetch_addr), .i_stall(o_stall), .o_mem_instr(i_mem_instr));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Compares one seen value with its expected value and counts it.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Issues one lookup; kind 0 expects no answer, 1 a hit, 2 a miss.
    task automatic look(input bit pm, input bit same_blk, input logic [23:0] a, input int kind);
        @(posedge i_sys_clk);
        #1;
        i_req_valid = 1'b1;
        i_req.pm_data = pm;
        i_req.dm_data = ~pm;
        i_req.dm_block = same_blk ? 24'h000000 : 24'h000001;
        i_req.fetch_block = 24'h000000;
        i_req.fetch_addr = a;
        @(posedge i_sys_clk);
        #1;
        i_req_valid = 1'b0;
        chk("hit", o_hit, kind == 1);
        chk("stall", o_stall, kind == 2);
        if (kind == 1) begin
            chk("instr", o_instr, {~a[11:0], a[11:0]});
        end
        if (kind == 2) begin
            @(posedge i_sys_clk);
            #1;
        end
    endtask : look
    // Moves a value into the control register, then idles pad cycles.
    task automatic wr_ctl(input logic [7:0] v, input int pad);
        @(posedge i_sys_clk);
        #1;
        i_reg_wr = 1'b1;
        i_reg_wdata = v;
        @(posedge i_sys_clk);
        #1;
        i_reg_wr = 1'b0;
        chk("ctl", o_reg_rdata, v & 8'he0);
        repeat (pad) @(posedge i_sys_clk);
    endtask : wr_ctl
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge i_sys_clk);
        #1;
        i_rst_n = 1'b1;
        chk("ctl_rst", o_reg_rdata, 8'ha0);
        chk("hit_rst", o_hit, 1'b0);
        chk("stall_rst", o_stall, 1'b0);
        look(1'b1, 1'b0, 24'h000103, 2);
        look(1'b1, 1'b0, 24'h000103, 1);
        look(1'b0, 1'b0, 24'h000210, 0);
        look(1'b0, 1'b1, 24'h000210, 2);
        look(1'b0, 1'b1, 24'h000210, 1);
        // Three addresses share set 3, so the recency bit decides the victim.
        look(1'b1, 1'b0, 24'h000123, 2);
        look(1'b1, 1'b0, 24'h000103, 1);
        look(1'b1, 1'b0, 24'h000143, 2);
        look(1'b1, 1'b0, 24'h000103, 1);
        look(1'b1, 1'b0, 24'h000123, 2);
        // That fill evicted the previous newcomer, so it misses once more.
        look(1'b1, 1'b0, 24'h000143, 2);
        look(1'b1, 1'b0, 24'h000123, 1);
        // A flush pulse leaves nothing valid behind.
        @(posedge i_sys_clk);
        #1;
        i_flush = 1'b1;
        @(posedge i_sys_clk);
        #1;
        i_flush = 1'b0;
        look(1'b1, 1'b0, 24'h000143, 2);
        // Reserved bits are written high and must read back as zero.
        wr_ctl(8'hbf, 4);
        // The old enables still rule a lookup taken five edges after the write.
        wr_ctl(8'h00, 3);
        look(1'b1, 1'b0, 24'h000400, 2);
        look(1'b1, 1'b0, 24'h000400, 1);
        look(1'b1, 1'b0, 24'h000401, 2);
        look(1'b1, 1'b0, 24'h000401, 2);
        wr_ctl(8'h20, 4);
        look(1'b1, 1'b0, 24'h000401, 2);
        look(1'b1, 1'b0, 24'h000401, 2);
        look(1'b0, 1'b1, 24'h000401, 2);
        look(1'b0, 1'b1, 24'h000401, 1);
        wr_ctl(8'h80, 4);
        look(1'b0, 1'b1, 24'h000402, 2);
        look(1'b0, 1'b1, 24'h000402, 2);
        wr_ctl(8'he0, 4);
        look(1'b1, 1'b0, 24'h000403, 2);
        look(1'b1, 1'b0, 24'h000403, 2);
        summarize();
    end
endmodule : cic_cache_bench
